// *** rtl/misc_option_pkg.sv ***
package misc_option_pkg;

   localparam logic [7:0] misc_option_two_offset   = 8'h7c;
   localparam logic [7:0] misc_option_three_offset = 8'h7d;
   localparam logic [7:0] misc_option_two_reset    = 8'h00;
   localparam logic [7:0] misc_option_three_reset  = 8'h00;

   // Field positions, misc_option_two
   localparam int addr_sel_bit        = 7;
   localparam int manual_ctrl_bit     = 6;
   localparam int long_filter_bit     = 5;
   localparam int bus_crc_bit         = 4;
   localparam int short_pulse_bit     = 3;
   localparam int first_noc_bit       = 2;
   localparam int first_oc_lsb        = 0;
   // Field positions, misc_option_three
   localparam int third_oc_lsb        = 6;
   localparam int second_oc_lsb       = 4;
   localparam int noc_softstart_bit   = 2;

   localparam logic [6:0] target_addr_a = 7'h4d;
   localparam logic [6:0] target_addr_b = 7'h4e;

   localparam int clk_mhz             = 100;
   localparam int long_filter_ms      = 30;
   localparam int long_pulse_ms       = 200;
   localparam int short_pulse_ms      = 20;
   localparam int long_filter_cycles  = long_filter_ms * clk_mhz * 1000;
   localparam int long_pulse_cycles   = long_pulse_ms * clk_mhz * 1000;
   localparam int short_pulse_cycles  = short_pulse_ms * clk_mhz * 1000;

   // Current-limit level select, one-hot style index
   typedef enum logic [1:0] {
      level_default = 2'b00,
      level_low     = 2'b01,
      level_high    = 2'b10
   } oc_level_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [6:0] target_addr;
      logic       manual_ctrl;
      logic       long_filter;
      logic       bus_crc_check;
      logic       short_pulse;
      logic       first_noc_high;
      oc_level_t  first_buck_oc;
      oc_level_t  third_buck_oc;
      oc_level_t  second_oc;
      logic       noc_softstart_only;
   } option_sel_t;

endpackage

// *** rtl/oc_level_decode.sv ***
`timescale 1ns/100ps
module oc_level_decode (
   input  wire logic [1:0]                   code_i,
   output misc_option_pkg::oc_level_t        level_o
);
   always_comb begin
      case (code_i)
         2'b01:   level_o = misc_option_pkg::level_low;
         2'b10:   level_o = misc_option_pkg::level_high;
         default: level_o = misc_option_pkg::level_default;
      endcase
   end
endmodule

// *** rtl/misc_option_config_regs.sv ***
// Behaviour
// - Bit 7 of option register two picks target address 0x4d (clear) or 0x4e (set).
// - Bit 6 of option register two moves output start and stop from enable pins to bus commands.
// - Bit 5 of option register two adds a 30 ms filter to under- and overvoltage on all outputs.
// - Bit 4 of option register two turns on CRC checking of bus transactions; host supplies it.
// - Bit 3 of option register two shortens the fault reset pulse to 20 ms for watchdog/sequence.
// - Under-, overvoltage and other faults always give a 200 ms fault reset pulse.
// - Bit 2 of option register two sets the first buck negative limit to 1 A instead of 800 mA.
// - Bits 1:0 of option register two pick the first buck overcurrent level, 1.50 A by default.
// - Bits 7:6 of option register three pick the third buck overcurrent level, 1.20 A default.
// - Bits 5:4 of option register three hold a second overcurrent level of the same kind.
// - Bit 2 of option register three limits negative-current truncation to soft-start only.
// - Option registers are written only in standby, then the host refreshes the CRC.
`timescale 1ns/100ps
module misc_option_config_regs (
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_n_i,
   input  wire misc_option_pkg::reg_req_t    req_i,
   input  wire logic                         standby_i,
   input  wire logic                         pin_enable_i,
   input  wire logic                         bus_enable_i,
   input  wire logic                         wdog_seq_fault_i,
   input  wire logic                         other_fault_i,
   input  wire logic                         undervoltage_fault_i,
   input  wire logic                         overvoltage_fault_i,
   output logic [7:0]                        rdata_o,
   output logic                              rd_valid_o,
   output misc_option_pkg::option_sel_t      option_o,
   output logic                              outputs_enable_o,
   output logic                              undervoltage_filtered_o,
   output logic                              overvoltage_filtered_o,
   output logic                              fault_reset_n_o,
   output logic                              reg_locked_o
);
   logic [7:0]                     misc_option_two_reg;
   logic [7:0]                     misc_option_three_reg;
   misc_option_pkg::oc_level_t     first_oc_lvl;
   misc_option_pkg::oc_level_t     third_oc_lvl;
   misc_option_pkg::oc_level_t     second_oc_lvl;
   logic [31:0]                    uv_cnt_reg;
   logic [31:0]                    ov_cnt_reg;
   logic [31:0]                    pulse_cnt_reg;

   // Writes accepted only in standby
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         misc_option_two_reg   <= misc_option_pkg::misc_option_two_reset;
         misc_option_three_reg <= misc_option_pkg::misc_option_three_reset;
      end else if (req_i.wr_en && standby_i) begin
         if (req_i.addr == misc_option_pkg::misc_option_two_offset) begin
            misc_option_two_reg <= req_i.wdata;
         end
         if (req_i.addr == misc_option_pkg::misc_option_three_offset) begin
            misc_option_three_reg <= {req_i.wdata[7:2], 2'b00};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o    <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= req_i.rd_en;
         if (req_i.addr == misc_option_pkg::misc_option_two_offset) begin
            rdata_o <= misc_option_two_reg;
         end else if (req_i.addr == misc_option_pkg::misc_option_three_offset) begin
            rdata_o <= misc_option_three_reg;
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_locked_o <= 1'b1;
      end else begin
         reg_locked_o <= !standby_i;
      end
   end

   oc_level_decode u_first_oc (
      .code_i  (misc_option_two_reg[misc_option_pkg::first_oc_lsb +: 2]),
      .level_o (first_oc_lvl)
   );
   oc_level_decode u_third_oc (
      .code_i  (misc_option_three_reg[misc_option_pkg::third_oc_lsb +: 2]),
      .level_o (third_oc_lvl)
   );
   oc_level_decode u_second_oc (
      .code_i  (misc_option_three_reg[misc_option_pkg::second_oc_lsb +: 2]),
      .level_o (second_oc_lvl)
   );

   // Static selects to the protection logic
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         option_o <= '0;
         option_o.target_addr <= misc_option_pkg::target_addr_a;
      end else begin
         option_o.target_addr <= misc_option_two_reg[misc_option_pkg::addr_sel_bit]
                                 ? misc_option_pkg::target_addr_b
                                 : misc_option_pkg::target_addr_a;
         option_o.manual_ctrl   <= misc_option_two_reg[misc_option_pkg::manual_ctrl_bit];
         option_o.long_filter   <= misc_option_two_reg[misc_option_pkg::long_filter_bit];
         option_o.bus_crc_check <= misc_option_two_reg[misc_option_pkg::bus_crc_bit];
         option_o.short_pulse   <= misc_option_two_reg[misc_option_pkg::short_pulse_bit];
         option_o.first_noc_high <= misc_option_two_reg[misc_option_pkg::first_noc_bit];
         option_o.first_buck_oc <= first_oc_lvl;
         option_o.third_buck_oc <= third_oc_lvl;
         option_o.second_oc     <= second_oc_lvl;
         option_o.noc_softstart_only <=
            misc_option_three_reg[misc_option_pkg::noc_softstart_bit];
      end
   end

   // Output enable source select
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         outputs_enable_o <= 1'b0;
      end else begin
         outputs_enable_o <= misc_option_two_reg[misc_option_pkg::manual_ctrl_bit]
                             ? bus_enable_i : pin_enable_i;
      end
   end

   // Voltage fault filter: fault must persist the filter time when enabled
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uv_cnt_reg              <= '0;
         ov_cnt_reg              <= '0;
         undervoltage_filtered_o <= 1'b0;
         overvoltage_filtered_o  <= 1'b0;
      end else if (misc_option_two_reg[misc_option_pkg::long_filter_bit]) begin
         uv_cnt_reg <= !undervoltage_fault_i ? '0
                       : (uv_cnt_reg < 32'(misc_option_pkg::long_filter_cycles))
                         ? uv_cnt_reg + 32'd1 : uv_cnt_reg;
         ov_cnt_reg <= !overvoltage_fault_i ? '0
                       : (ov_cnt_reg < 32'(misc_option_pkg::long_filter_cycles))
                         ? ov_cnt_reg + 32'd1 : ov_cnt_reg;
         undervoltage_filtered_o <= undervoltage_fault_i &&
            (uv_cnt_reg >= 32'(misc_option_pkg::long_filter_cycles - 1));
         overvoltage_filtered_o  <= overvoltage_fault_i &&
            (ov_cnt_reg >= 32'(misc_option_pkg::long_filter_cycles - 1));
      end else begin
         uv_cnt_reg              <= '0;
         ov_cnt_reg              <= '0;
         undervoltage_filtered_o <= undervoltage_fault_i;
         overvoltage_filtered_o  <= overvoltage_fault_i;
      end
   end

   // Fault reset pulse generator
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_cnt_reg   <= '0;
         fault_reset_n_o <= 1'b1;
      end else if (pulse_cnt_reg != '0) begin
         pulse_cnt_reg   <= pulse_cnt_reg - 32'd1;
         fault_reset_n_o <= (pulse_cnt_reg == 32'd1);
      end else if (other_fault_i || undervoltage_filtered_o || overvoltage_filtered_o) begin
         pulse_cnt_reg   <= 32'(misc_option_pkg::long_pulse_cycles);
         fault_reset_n_o <= 1'b0;
      end else if (wdog_seq_fault_i) begin
         pulse_cnt_reg   <= misc_option_two_reg[misc_option_pkg::short_pulse_bit]
                            ? 32'(misc_option_pkg::short_pulse_cycles)
                            : 32'(misc_option_pkg::long_pulse_cycles);
         fault_reset_n_o <= 1'b0;
      end
   end
endmodule

// *** verification/misc_option_config_regs_checker.sv ***
`timescale 1ns/100ps
module misc_option_config_regs_checker (
   input wire logic                         sys_clk_i,
   input wire logic                         rst_n_i,
   input wire misc_option_pkg::reg_req_t    req_i,
   input wire logic                         standby_i,
   input wire logic                         pin_enable_i,
   input wire logic                         bus_enable_i,
   input wire logic                         wdog_seq_fault_i,
   input wire logic                         other_fault_i,
   input wire logic [7:0]                   rdata_o,
   input wire logic                         rd_valid_o,
   input wire misc_option_pkg::option_sel_t option_o,
   input wire logic                         outputs_enable_o,
   input wire logic                         fault_reset_n_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   function automatic misc_option_pkg::oc_level_t lvl(input logic [1:0] c);
      if (c == 2'b01) return misc_option_pkg::level_low;
      if (c == 2'b10) return misc_option_pkg::level_high;
      return misc_option_pkg::level_default;
   endfunction
   sequence s_wr_two;
      req_i.wr_en && standby_i && req_i.addr == 8'h7c;
   endsequence
   sequence s_wr_three;
      req_i.wr_en && standby_i && req_i.addr == 8'h7d;
   endsequence
   chk_addr_select: assert property (
      s_wr_two |-> ##2 option_o.target_addr == ($past(req_i.wdata[7], 2) ?
      misc_option_pkg::target_addr_b : misc_option_pkg::target_addr_a))
      else $error("target address select wrong");
   chk_pulse_select: assert property (
      s_wr_two |-> ##2 option_o.short_pulse == $past(req_i.wdata[3], 2)
      && option_o.first_noc_high == $past(req_i.wdata[2], 2))
      else $error("pulse or negative limit select wrong");
   chk_three_decode: assert property (
      s_wr_three |-> ##2 option_o.third_buck_oc == lvl($past(req_i.wdata[7:6], 2))
      && option_o.noc_softstart_only == $past(req_i.wdata[2], 2))
      else $error("third register decode wrong");
   chk_refused_write: assert property (
      req_i.wr_en && !standby_i |-> ##2 $stable(option_o))
      else $error("write outside standby took effect");
   chk_read_back: assert property (
      s_wr_two ##1 (req_i.addr == 8'h7c && !req_i.wr_en) |=> rdata_o == $past(req_i.wdata, 2))
      else $error("read back differs from write");
   chk_unmapped_read: assert property (
      req_i.rd_en && req_i.addr != 8'h7c && req_i.addr != 8'h7d |=> rd_valid_o && rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_output_select: assert property (
      $past(rst_n_i) |-> outputs_enable_o ==
      (option_o.manual_ctrl ? $past(bus_enable_i) : $past(pin_enable_i)))
      else $error("output enable source wrong");
   chk_pulse_start: assert property (
      fault_reset_n_o && (other_fault_i || wdog_seq_fault_i) |=> !fault_reset_n_o)
      else $error("fault pulse did not start");
   chk_pulse_hold: assert property (
      $fell(fault_reset_n_o) |-> !fault_reset_n_o [*8])
      else $error("fault pulse too short");
endmodule
bind misc_option_config_regs misc_option_config_regs_checker misc_option_config_regs_checker_i (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .standby_i(standby_i),
   .pin_enable_i(pin_enable_i), .bus_enable_i(bus_enable_i), .other_fault_i(other_fault_i),
   .wdog_seq_fault_i(wdog_seq_fault_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
   .option_o(option_o), .outputs_enable_o(outputs_enable_o), .fault_reset_n_o(fault_reset_n_o));

// *** verification/reg_host_model.sv ***
`timescale 1ns/100ps
module reg_host_model (
   input  wire logic                    sys_clk_i,
   input  wire logic [7:0]              rdata_i,
   input  wire logic                    rd_valid_i,
   output misc_option_pkg::reg_req_t    req_o
);
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      req_o = '{1'b1, 1'b0, a, d};
      @(negedge sys_clk_i);
      req_o.wr_en = 1'b0;
      req_o.wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      req_o = '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk_i);
      #1;
      d = rd_valid_i ? rdata_i : 8'hxx;
      @(negedge sys_clk_i);
      req_o = '{1'b0, 1'b0, a, 8'hff};
   endtask
endmodule

// *** verification/misc_option_config_regs_tb_top.sv ***
`timescale 1ns/100ps
module misc_option_config_regs_tb_top;
   logic                         sys_clk_i, rst_n_i, stby, pin, bus, wdog, other, uv, ov;
   logic                         rd_valid, out_en, uv_f, ov_f, frst_n, locked;
   logic [7:0]                   rdata, d;
   misc_option_pkg::reg_req_t    req;
   misc_option_pkg::option_sel_t opt;
   int                           err_count = 0, checks = 0, cyc = 0;
   logic [7:0]                   t2 [4] = '{8'h88, 8'h77, 8'h42, 8'h01};
   logic [7:0]                   t3 [4] = '{8'hff, 8'h40, 8'h94, 8'h24};
   reg_host_model reg_host_model_i (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
      .rd_valid_i(rd_valid), .req_o(req));
   misc_option_config_regs misc_option_config_regs_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .req_i(req), .standby_i(stby), .pin_enable_i(pin), .bus_enable_i(bus),
      .wdog_seq_fault_i(wdog), .other_fault_i(other), .undervoltage_fault_i(uv),
      .overvoltage_fault_i(ov), .rdata_o(rdata), .rd_valid_o(rd_valid), .option_o(opt),
      .outputs_enable_o(out_en), .undervoltage_filtered_o(uv_f), .overvoltage_filtered_o(ov_f),
      .fault_reset_n_o(frst_n), .reg_locked_o(locked));
   function automatic misc_option_pkg::oc_level_t lvl(input logic [1:0] c);
      if (c == 2'b01) return misc_option_pkg::level_low;
      if (c == 2'b10) return misc_option_pkg::level_high;
      return misc_option_pkg::level_default;
   endfunction
   function automatic misc_option_pkg::option_sel_t eo(input logic [7:0] a, input logic [7:0] b);
      return '{a[7] ? misc_option_pkg::target_addr_b : misc_option_pkg::target_addr_a, a[6],
         a[5], a[4], a[3], a[2], lvl(a[1:0]), lvl(b[7:6]), lvl(b[5:4]), b[2]};
   endfunction
   task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      {rst_n_i, wdog, other, uv, ov, bus} = '0;
      {stby, pin} = 2'b11;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i) rst_n_i = 1'b1;
      compare(opt, eo(8'h00, 8'h00), "reset decode");
      for (int i = 0; i < 4; i++) begin
         reg_host_model_i.wr(8'h7c, t2[i]);
         reg_host_model_i.wr(8'h7d, t3[i]);
         reg_host_model_i.rd(8'h7c, d);
         compare(d, t2[i], "read two");
         reg_host_model_i.rd(8'h7d, d);
         compare(d, t3[i] & 8'hfc, "read three");
         compare(opt, eo(t2[i], t3[i]), "decode");
      end
      compare(out_en, 1'b1, "pin source");
      reg_host_model_i.wr(8'h7c, 8'h40);
      repeat (2) @(negedge sys_clk_i);
      compare(out_en, 1'b0, "bus source");
      stby = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      compare(locked, 1'b1, "lock");
      reg_host_model_i.wr(8'h7c, 8'hff);
      stby = 1'b1;
      reg_host_model_i.rd(8'h7c, d);
      compare(d, 8'h40, "refused write");
      reg_host_model_i.wr(8'h7b, 8'h55);
      reg_host_model_i.rd(8'h7b, d);
      compare(d, 8'h00, "unmapped");
      other = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      other = 1'b0;
      compare(frst_n, 1'b0, "fault pulse");
      {uv, ov} = 2'b11;
      repeat (2) @(negedge sys_clk_i);
      compare(uv_f, 1'b1, "unfiltered");
      compare(ov_f, 1'b1, "unfiltered ov");
      {uv, ov} = 2'b00;
      reg_host_model_i.wr(8'h7c, 8'h20);
      uv = 1'b1;
      repeat (10) @(negedge sys_clk_i);
      compare(uv_f, 1'b0, "filtered");
      {uv, rst_n_i} = 2'b00;
      repeat (2) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      compare(frst_n, 1'b1, "second reset");
      wdog = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      compare(frst_n, 1'b0, "sequence fault pulse");
      print_verdict();
   end
endmodule
